//--- logic/tba_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module tba_ctrl_end (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  // tag bus link
  tba_if.ctrl_end          BUS,
  // ownership control
  input  wire logic        I_WANT_BUS,
  input  wire logic        I_RECALL,
  output logic             O_OWNS_BUS,
  // command port
  input  wire logic        I_CMD_VALID,
  input  wire logic [1:0]  I_CMD_KIND,
  input  wire logic [19:0] I_CMD_TAG,
  input  wire logic [10:0] I_CMD_INDEX,
  input  wire logic [1:0]  I_CMD_SECTOR,
  input  wire logic [1:0]  I_CMD_SET,
  output logic             O_CMD_READY,
  output logic             O_RD_VALID,
  output logic [19:0]      O_RD_TAG,
  // tag ram control pins
  output logic [1:0]       O_TAG_SET_SELECT,
  output logic             O_TAG_ADDR_WRITE_EN_N,
  output logic             O_STATE_WRITE_EN_N,
  output logic             O_STATE_READ_SEL_N,
  output logic             O_TAG_RAM_OE_N
);

  typedef struct packed {
    tba_pkg::tba_arb_t state;
    logic              req_n;
    logic              tbus_oe_n;
    logic [67:0]       tbus_out;
    logic [3:0]        op_cnt;
    tba_pkg::tba_cmd_t op_kind;
    logic [1:0]        set_keep;
    logic [1:0]        set_sel;
    logic              tag_we_n;
    logic              state_we_n;
    logic              state_rd_n;
    logic              tag_oe_n;
    logic              rd_valid;
    logic [19:0]       rd_tag;
    logic              ready;
    logic              owns;
  } tba_ctrl_st_t;

  tba_ctrl_st_t r_reg;
  tba_ctrl_st_t r_next;

  // next state of the whole controller end
  always_comb begin
    logic             accept;
    logic             rd_active;
    logic [3:0]       fn;
    logic [3:0]       last;
    tba_pkg::tba_arb_t ns;
    r_next    = r_reg;
    last      = '0;
    fn        = BUS.tbus[tba_pkg::FN_HI:tba_pkg::FN_LO];
    ns        = tba_pkg::arb_next(r_reg.state, r_reg.req_n, BUS.cpu_bus_release_n, fn);
    r_next.state = ns;
    accept    = r_reg.ready && I_CMD_VALID;
    r_next.rd_valid = 1'b0;
    // operation sequencing, op_cnt equals the clock number of the operation
    if (accept) begin
      r_next.op_kind  = tba_pkg::tba_cmd_t'(I_CMD_KIND);
      r_next.set_keep = I_CMD_SET;
      r_next.op_cnt   = tba_pkg::OP_FIRST;
      r_next.tbus_out = '0;
      unique case (tba_pkg::tba_cmd_t'(I_CMD_KIND))
        tba_pkg::CMD_TAG_WRITE: begin
          r_next.tbus_out[tba_pkg::TAG_HI:tba_pkg::TAG_LO] = tba_pkg::tag_to_field(I_CMD_TAG);
          r_next.tbus_out[tba_pkg::IDX_HI:tba_pkg::IDX_LO] = I_CMD_INDEX;
          r_next.tbus_out[tba_pkg::SEC_HI:tba_pkg::SEC_LO] = I_CMD_SECTOR;
        end
        tba_pkg::CMD_TAG_READ: begin
          r_next.tbus_out[tba_pkg::IDX_HI:tba_pkg::IDX_LO] = I_CMD_INDEX;
          r_next.tbus_out[tba_pkg::FN_HI:tba_pkg::FN_LO]   = tba_pkg::FN_EVEN_READ;
        end
        tba_pkg::CMD_FLUSH: begin
          r_next.tbus_out[tba_pkg::FN_HI:tba_pkg::FN_LO] = tba_pkg::FN_FLUSH_QUEUE;
        end
        tba_pkg::CMD_DROP_BUS: begin
          r_next.tbus_out[tba_pkg::FN_HI:tba_pkg::FN_LO] = tba_pkg::FN_IDLE;
        end
      endcase
    end else if (r_reg.op_cnt != '0) begin
      last = (r_reg.op_kind == tba_pkg::CMD_TAG_READ)  ? tba_pkg::OP_RD_RETURN :
             (r_reg.op_kind == tba_pkg::CMD_TAG_WRITE) ? tba_pkg::OP_WR_LAST   :
                                                         tba_pkg::OP_FIRST;
      r_next.op_cnt = (r_reg.op_cnt == last) ? 4'h0 : 4'(r_reg.op_cnt + 4'h1);
    end
    // function field is valid for clock 1 only
    if (r_reg.op_cnt == tba_pkg::OP_FIRST)
      r_next.tbus_out[tba_pkg::FN_HI:tba_pkg::FN_LO] = tba_pkg::FN_IDLE;
    rd_active = (r_next.op_kind == tba_pkg::CMD_TAG_READ) && (r_next.op_cnt != '0);
    // hard-wired tag ram controls, clocks 3 to 5
    if (r_next.op_cnt == tba_pkg::OP_SET_CLK) r_next.set_sel = r_next.set_keep;
    r_next.tag_we_n   = !((r_next.op_kind == tba_pkg::CMD_TAG_WRITE) &&
                          (r_next.op_cnt == tba_pkg::OP_SET_CLK));
    r_next.state_we_n = 1'b1;
    r_next.state_rd_n = 1'b1;
    r_next.tag_oe_n   = !(rd_active && (r_next.op_cnt >= tba_pkg::OP_OE_FIRST) &&
                          (r_next.op_cnt <= tba_pkg::OP_OE_LAST));
    // returned tag arrives in clock 8
    if ((r_reg.op_kind == tba_pkg::CMD_TAG_READ) && (r_reg.op_cnt == tba_pkg::OP_RD_RETURN)) begin
      r_next.rd_tag   = tba_pkg::field_to_tag(BUS.tbus[tba_pkg::TAG_HI:tba_pkg::TAG_LO]);
      r_next.rd_valid = 1'b1;
    end
    // bus request
    unique case (ns)
      tba_pkg::ARB_RUN, tba_pkg::ARB_REQUEST, tba_pkg::ARB_RELEASE:
        r_next.req_n = !(I_WANT_BUS || rd_active);
      tba_pkg::ARB_QUEUE_DRAIN:
        r_next.req_n = !I_RECALL;
      tba_pkg::ARB_TO_CPU_TURNAROUND:
        r_next.req_n = 1'b1;
      tba_pkg::ARB_CTRL_OWNS:
        r_next.req_n = (rd_active && r_next.op_cnt == tba_pkg::OP_RD_DROP) ||
                       (r_next.op_cnt == tba_pkg::OP_FIRST &&
                        r_next.op_kind != tba_pkg::CMD_TAG_WRITE &&
                        r_next.op_kind != tba_pkg::CMD_TAG_READ);
      default:
        r_next.req_n = 1'b0;
    endcase
    // ownership and bus drive
    r_next.owns      = (ns == tba_pkg::ARB_CTRL_OWNS);
    r_next.tbus_oe_n = !r_next.owns;
    r_next.ready     = r_next.owns && (r_next.op_cnt == '0) && !r_next.req_n;
  end

  // state register
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      r_reg            <= '0;
      r_reg.state      <= tba_pkg::ARB_RUN;
      r_reg.req_n      <= 1'b1;
      r_reg.tbus_oe_n  <= 1'b1;
      r_reg.tag_we_n   <= 1'b1;
      r_reg.state_we_n <= 1'b1;
      r_reg.state_rd_n <= 1'b1;
      r_reg.tag_oe_n   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs from flip-flops
  assign BUS.ctrl_tbus_out      = r_reg.tbus_out;
  assign BUS.ctrl_tbus_oe_n     = r_reg.tbus_oe_n;
  assign BUS.ctrl_bus_request_n = r_reg.req_n;
  assign O_OWNS_BUS             = r_reg.owns;
  assign O_CMD_READY            = r_reg.ready;
  assign O_RD_VALID             = r_reg.rd_valid;
  assign O_RD_TAG               = r_reg.rd_tag;
  assign O_TAG_SET_SELECT       = r_reg.set_sel;
  assign O_TAG_ADDR_WRITE_EN_N  = r_reg.tag_we_n;
  assign O_STATE_WRITE_EN_N     = r_reg.state_we_n;
  assign O_STATE_READ_SEL_N     = r_reg.state_rd_n;
  assign O_TAG_RAM_OE_N         = r_reg.tag_oe_n;

endmodule
`default_nettype wire

//--- logic/tba_pkg.sv
`default_nettype none
package tba_pkg;

  // tag bus layout
  localparam int TBUS_W   = 68;
  localparam int FN_HI    = 67;
  localparam int FN_LO    = 64;
  localparam int FN_W     = 4;
  localparam int TAG_HI   = 39;
  localparam int TAG_LO   = 20;
  localparam int IDX_HI   = 19;
  localparam int IDX_LO   = 9;
  localparam int SEC_HI   = 8;
  localparam int SEC_LO   = 7;
  localparam int FWD_HI   = 39;
  localparam int FWD_LO   = 5;
  localparam int FWD_W    = FWD_HI - FWD_LO + 1;
  localparam int RET_W    = 40;
  localparam int TAG_W    = 20;
  localparam int IDX_W    = 11;
  localparam int SEC_W    = 2;
  localparam int SET_W    = 2;
  localparam int ROT      = 2;

  // function field codes
  localparam logic [FN_W-1:0] FN_IDLE        = 4'h0;
  localparam logic [FN_W-1:0] FN_EVEN_READ   = 4'h5;
  localparam logic [FN_W-1:0] FN_FLUSH_QUEUE = 4'h7;

  // grant deadline after entering the request state
  localparam int          REQ_GRANT_MAX_CLK = 1500;
  localparam int          CNT_W             = 11;
  localparam logic [CNT_W-1:0] REQ_FORCE_CNT = CNT_W'(REQ_GRANT_MAX_CLK - 4);

  // cycle numbers within one tag bus operation (clock 1 = first bus word)
  localparam int          OP_W        = 4;
  localparam logic [OP_W-1:0] OP_FIRST     = 4'h1;
  localparam logic [OP_W-1:0] OP_SET_CLK   = 4'h3;
  localparam logic [OP_W-1:0] OP_OE_FIRST  = 4'h4;
  localparam logic [OP_W-1:0] OP_OE_LAST   = 4'h5;
  localparam logic [OP_W-1:0] OP_RD_TRACK  = 4'h2;
  localparam logic [OP_W-1:0] OP_RD_GRAB   = 4'h5;
  localparam logic [OP_W-1:0] OP_RD_LOAD   = 4'h7;
  localparam logic [OP_W-1:0] OP_RD_RETURN = 4'h8;
  localparam logic [OP_W-1:0] OP_RD_DROP   = 4'h6;
  localparam logic [OP_W-1:0] OP_WR_LAST   = 4'h3;

  // arbiter states
  typedef enum logic [8:0] {
    ARB_RUN                 = 9'h001,
    ARB_REQUEST             = 9'h002,
    ARB_TO_CTRL_TURNAROUND  = 9'h004,
    ARB_CTRL_OWNS           = 9'h008,
    ARB_TO_CPU_TURNAROUND   = 9'h010,
    ARB_QUEUE_DRAIN         = 9'h020,
    ARB_DRAIN_RECALL        = 9'h040,
    ARB_DRAIN_RETURN_TURN   = 9'h080,
    ARB_RELEASE             = 9'h100
  } tba_arb_t;

  // controller commands
  typedef enum logic [1:0] {
    CMD_TAG_WRITE = 2'h0,
    CMD_TAG_READ  = 2'h1,
    CMD_FLUSH     = 2'h2,
    CMD_DROP_BUS  = 2'h3
  } tba_cmd_t;

  // shared arbiter transition, both ends evaluate the same pins
  function automatic tba_arb_t arb_next(input tba_arb_t st, input logic req_n,
                                        input logic rel_n, input logic [FN_W-1:0] fn);
    tba_arb_t nx;
    nx = st;
    unique case (st)
      ARB_RUN: begin
        if (!rel_n) nx = ARB_TO_CTRL_TURNAROUND;
        else if (!req_n) nx = ARB_REQUEST;
      end
      ARB_REQUEST: begin
        if (!rel_n) nx = ARB_TO_CTRL_TURNAROUND;
      end
      ARB_TO_CTRL_TURNAROUND: nx = ARB_CTRL_OWNS;
      ARB_CTRL_OWNS: begin
        if (fn == FN_FLUSH_QUEUE) nx = ARB_TO_CPU_TURNAROUND;
        else if (req_n) nx = ARB_RELEASE;
      end
      ARB_TO_CPU_TURNAROUND: nx = ARB_QUEUE_DRAIN;
      ARB_QUEUE_DRAIN: begin
        if (!rel_n) nx = ARB_DRAIN_RETURN_TURN;
        else if (!req_n) nx = ARB_DRAIN_RECALL;
      end
      ARB_DRAIN_RECALL: begin
        if (!rel_n) nx = ARB_DRAIN_RETURN_TURN;
      end
      ARB_DRAIN_RETURN_TURN: nx = ARB_CTRL_OWNS;
      ARB_RELEASE: nx = ARB_RUN;
      default: nx = ARB_RUN;
    endcase
    return nx;
  endfunction

  // tag ram tag to bus field: bus bit 22 carries tag bit 0
  function automatic logic [TAG_W-1:0] tag_to_field(input logic [TAG_W-1:0] tag);
    return {tag[TAG_W-ROT-1:0], tag[TAG_W-1:TAG_W-ROT]};
  endfunction

  function automatic logic [TAG_W-1:0] field_to_tag(input logic [TAG_W-1:0] fld);
    return {fld[ROT-1:0], fld[TAG_W-1:ROT]};
  endfunction

endpackage
`default_nettype wire

//--- logic/tba_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tba_if;
  logic [67:0] cpu_tbus_out;
  logic        cpu_tbus_oe_n;
  logic [67:0] ctrl_tbus_out;
  logic        ctrl_tbus_oe_n;
  logic        ctrl_bus_request_n;
  logic        cpu_bus_release_n;
  wire  [67:0] tbus;

  // resolved shared bus level, idle bus reads low
  assign tbus = !cpu_tbus_oe_n  ? cpu_tbus_out  :
                !ctrl_tbus_oe_n ? ctrl_tbus_out : '0;

  modport cpu_end (output cpu_tbus_out, output cpu_tbus_oe_n, output cpu_bus_release_n,
                   input tbus, input ctrl_bus_request_n);
  modport ctrl_end (output ctrl_tbus_out, output ctrl_tbus_oe_n, output ctrl_bus_request_n,
                    input tbus, input cpu_bus_release_n);
endinterface
`default_nettype wire

//--- logic/tba_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - controller request moves run to request state
// - cpu may release unasked, e.g. on miss
// - grant within 1500 clocks of request state
// - request state holds until release, then turnaround
// - turnaround one clock, then controller owns bus
// - function field 0111 forces cpu-bound turnaround
// - one clock turnaround, then queue drain, cpu drives
// - queue empty: release, turnaround back to controller
// - request during drain: recall, release after operation
// - request dropped without flush code: release state
// - release state lasts one clock, then run
// - leftover queue entries wait for next ownership
// - tag write carries tag, index, sector fields
// - bus bits 39:5 reach tag pins two clocks later
// - controller drives set select, tag write enable clock 3
// - tag field routed rotated by two bits
// - index and sector bits routed from bus
// - function 5h marks even tag read
// - controller sends index clock 1, set clock 3
// - controller enables tag ram output clock 4
// - cpu returns read tag on bus clock 8
// - controller drops request clock 6, cpu releases clock 9 (here only if I_BUSY low, else held in request state)
// - read return drives all 40 low bus bits
module tba_cpu_end (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  // tag bus link
  tba_if.cpu_end           BUS,
  // core side
  input  wire logic [67:0] I_TBUS_DATA,
  input  wire logic        I_GIVE_UP,
  input  wire logic        I_BUSY,
  input  wire logic        I_QUEUE_EMPTY,
  output logic             O_OWNS_BUS,
  output logic             O_DRAIN_QUEUE,
  output logic [8:0]       O_ARB_STATE,
  // tag ram pins
  output logic [19:0]      O_TAG_PIN,
  output logic             O_TAG_PIN_OE_N,
  input  wire logic [19:0] I_TAG_PIN,
  output logic [10:0]      O_INDEX_PIN,
  output logic [1:0]       O_SECTOR_PIN
);

  typedef struct packed {
    tba_pkg::tba_arb_t state;
    logic              rel_n;
    logic              tbus_oe_n;
    logic [67:0]       tbus_out;
    logic [10:0]       wait_cnt;
    logic [34:0]       fwd;
    logic [19:0]       tag_pin;
    logic              tag_oe_n;
    logic [10:0]       idx_pin;
    logic [1:0]        sec_pin;
    logic [3:0]        rd_cnt;
    logic [19:0]       rd_tag;
    logic              owns;
    logic              drain;
  } tba_cpu_st_t;

  localparam int F_TAG_HI = tba_pkg::TAG_HI - tba_pkg::FWD_LO;
  localparam int F_TAG_LO = tba_pkg::TAG_LO - tba_pkg::FWD_LO;
  localparam int F_IDX_HI = tba_pkg::IDX_HI - tba_pkg::FWD_LO;
  localparam int F_IDX_LO = tba_pkg::IDX_LO - tba_pkg::FWD_LO;
  localparam int F_SEC_HI = tba_pkg::SEC_HI - tba_pkg::FWD_LO;
  localparam int F_SEC_LO = tba_pkg::SEC_LO - tba_pkg::FWD_LO;

  tba_cpu_st_t r_reg;
  tba_cpu_st_t r_next;

  // next state of the whole cpu end
  always_comb begin
    logic              give;
    logic              rd_clear;
    logic [3:0]        fn;
    logic [39:0]       ret;
    tba_pkg::tba_arb_t ns;
    r_next   = r_reg;
    give     = 1'b0;
    fn       = BUS.tbus[tba_pkg::FN_HI:tba_pkg::FN_LO];
    ns       = tba_pkg::arb_next(r_reg.state, BUS.ctrl_bus_request_n, r_reg.rel_n, fn);
    r_next.state = ns;
    // two-stage forward of bus bits 39:5 to the tag ram pins
    r_next.fwd     = BUS.tbus[tba_pkg::FWD_HI:tba_pkg::FWD_LO];
    r_next.tag_pin = tba_pkg::field_to_tag(r_reg.fwd[F_TAG_HI:F_TAG_LO]);
    r_next.idx_pin = r_reg.fwd[F_IDX_HI:F_IDX_LO];
    r_next.sec_pin = r_reg.fwd[F_SEC_HI:F_SEC_LO];
    // even tag read tracking, rd_cnt equals the read's clock number
    if (r_reg.rd_cnt != '0)
      r_next.rd_cnt = (r_reg.rd_cnt == tba_pkg::OP_RD_RETURN) ? 4'h0 : 4'(r_reg.rd_cnt + 4'h1);
    else if (r_reg.state == tba_pkg::ARB_CTRL_OWNS && fn == tba_pkg::FN_EVEN_READ)
      r_next.rd_cnt = tba_pkg::OP_RD_TRACK;
    if (r_reg.rd_cnt == tba_pkg::OP_RD_GRAB) r_next.rd_tag = I_TAG_PIN;
    r_next.tag_oe_n = (r_next.rd_cnt != '0); // pins turned round while the ram answers
    // wait counter in the request state
    r_next.wait_cnt = (r_reg.state == tba_pkg::ARB_REQUEST) ? 11'(r_reg.wait_cnt + 11'h001) : '0;
    // release decision, held off while a read return is outstanding
    rd_clear = (r_reg.rd_cnt == '0) || (r_reg.rd_cnt == tba_pkg::OP_RD_RETURN);
    unique case (ns)
      tba_pkg::ARB_RUN:
        give = rd_clear && (I_GIVE_UP || r_reg.rd_cnt == tba_pkg::OP_RD_RETURN);
      tba_pkg::ARB_REQUEST:
        give = rd_clear && (!I_BUSY || r_reg.wait_cnt >= tba_pkg::REQ_FORCE_CNT);
      tba_pkg::ARB_QUEUE_DRAIN:
        give = I_QUEUE_EMPTY;
      tba_pkg::ARB_DRAIN_RECALL:
        give = !I_BUSY;
      default:
        give = 1'b0;
    endcase
    r_next.rel_n = !give;
    // bus drive while cpu owns; queued stores wait for ownership
    r_next.owns = (ns == tba_pkg::ARB_RUN) || (ns == tba_pkg::ARB_REQUEST) ||
                  (ns == tba_pkg::ARB_QUEUE_DRAIN) || (ns == tba_pkg::ARB_DRAIN_RECALL);
    r_next.drain     = (ns == tba_pkg::ARB_QUEUE_DRAIN);
    r_next.tbus_oe_n = !r_next.owns;
    r_next.tbus_out  = I_TBUS_DATA;
    // read return in clock 8 covers bits 39:0
    ret = '0;
    ret[tba_pkg::TAG_HI:tba_pkg::TAG_LO] = tba_pkg::tag_to_field(r_reg.rd_tag);
    if (r_reg.rd_cnt == tba_pkg::OP_RD_LOAD)
      r_next.tbus_out = {I_TBUS_DATA[tba_pkg::TBUS_W-1:tba_pkg::RET_W], ret};
  end

  // state register
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      r_reg           <= '0;
      r_reg.state     <= tba_pkg::ARB_RUN;
      r_reg.rel_n     <= 1'b1;
      r_reg.tbus_oe_n <= 1'b1;
      r_reg.tag_oe_n  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs from flip-flops
  assign BUS.cpu_tbus_out      = r_reg.tbus_out;
  assign BUS.cpu_tbus_oe_n     = r_reg.tbus_oe_n;
  assign BUS.cpu_bus_release_n = r_reg.rel_n;
  assign O_OWNS_BUS            = r_reg.owns;
  assign O_DRAIN_QUEUE         = r_reg.drain;
  assign O_ARB_STATE           = r_reg.state;
  assign O_TAG_PIN             = r_reg.tag_pin;
  assign O_TAG_PIN_OE_N        = r_reg.tag_oe_n;
  assign O_INDEX_PIN           = r_reg.idx_pin;
  assign O_SECTOR_PIN          = r_reg.sec_pin;

endmodule
`default_nettype wire

//--- bench/tba_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tba_chk (
  // clock and reset
  input wire logic        I_CLK,
  input wire logic        I_NRST,
  // link pins
  input wire logic [67:0] cpu_tbus_out,
  input wire logic        cpu_tbus_oe_n,
  input wire logic [67:0] ctrl_tbus_out,
  input wire logic        ctrl_tbus_oe_n,
  input wire logic        ctrl_bus_request_n,
  input wire logic        cpu_bus_release_n,
  input wire logic [67:0] tbus
);
  // one request cycle in run plus the request state allowance
  localparam int GRANT_MAX = 1501;
  logic [10:0] wait_reg;
  logic        ctl_own;
  logic [3:0]  fn;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // ownership and function field decode
  assign ctl_own = !ctrl_tbus_oe_n && cpu_tbus_oe_n;
  assign fn = tbus[67:64];
  // cycles the cpu keeps the bus against a pending request
  always_ff @(posedge I_CLK) begin
    if (!I_NRST || ctrl_bus_request_n || cpu_tbus_oe_n) wait_reg <= 11'h000;
    else wait_reg <= wait_reg + 11'h001;
  end
  AST_NO_CLASH: assert property (cpu_tbus_oe_n || ctrl_tbus_oe_n)
    else $error("both ends drive the tag bus");
  AST_REL_PULSE: assert property ($fell(cpu_bus_release_n) |=> cpu_bus_release_n)
    else $error("release held longer than one cycle");
  AST_TURN_CTRL: assert property (!cpu_bus_release_n |=>
    (cpu_tbus_oe_n && ctrl_tbus_oe_n) ##1 ctl_own)
    else $error("no one-cycle turnaround to controller");
  AST_OWN_HOLD: assert property (!cpu_tbus_oe_n && cpu_bus_release_n |=> !cpu_tbus_oe_n)
    else $error("cpu lost the bus without release");
  AST_FLUSH: assert property (ctl_own && fn == 4'h7 |=>
    (cpu_tbus_oe_n && ctrl_tbus_oe_n) ##1 !cpu_tbus_oe_n)
    else $error("flush code did not hand bus to cpu");
  AST_DROP: assert property (ctl_own && fn != 4'h7 && ctrl_bus_request_n |=>
    (cpu_tbus_oe_n && ctrl_tbus_oe_n) ##1 !cpu_tbus_oe_n)
    else $error("request drop did not return bus to cpu");
  AST_READ_RET: assert property (ctl_own && fn == 4'h5 |-> ##5 ctrl_bus_request_n
    ##1 (cpu_tbus_oe_n && ctrl_tbus_oe_n) ##1 !cpu_tbus_oe_n ##1 !cpu_bus_release_n)
    else $error("even read return sequence wrong");
  AST_GRANT: assert property (int'(wait_reg) <= GRANT_MAX)
    else $error("grant deadline exceeded");
  cover property (ctl_own && fn == 4'h7);
  cover property (ctl_own && fn == 4'h5);
  cover property (wait_reg > 11'h3e8);
endmodule
`default_nettype wire

//--- bench/tag_bus_arbiter_tag_cycles_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tag_bus_arbiter_tag_cycles_tb_top;
  logic        clk, nrst, give_up, busy, q_empty, want, recall, c_v;
  logic        cpu_owns, drain, ctrl_owns, ready, rd_v, twe_n, swe_n, ram_oe_n;
  logic        srd_n, tpin_oe_n;
  logic [67:0] core_word, tb_bus;
  logic [1:0]  c_k, c_sec, c_set, sec_pin, set_sel;
  logic [19:0] c_tag, tag_pin, tag_in, rd_tag, ram_tag;
  logic [10:0] c_idx, idx_pin;
  logic [8:0]  arb_st;
  logic [19:0] exp_rd[$];
  logic [35:0] exp_wr[$];
  int          fails = 0, n_compared = 0, cycles = 0, t0;
  int          seed = 32'hf921_82e1;
  tba_if tba_if_i ();
  assign tb_bus = tba_if_i.tbus;
  tba_cpu_end tba_cpu_end_i (
    .I_CLK(clk), .I_NRST(nrst), .BUS(tba_if_i), .I_TBUS_DATA(core_word), .I_GIVE_UP(give_up),
    .I_BUSY(busy), .I_QUEUE_EMPTY(q_empty), .O_OWNS_BUS(cpu_owns), .O_DRAIN_QUEUE(drain),
    .O_ARB_STATE(arb_st), .O_TAG_PIN(tag_pin), .O_TAG_PIN_OE_N(tpin_oe_n), .I_TAG_PIN(tag_in),
    .O_INDEX_PIN(idx_pin), .O_SECTOR_PIN(sec_pin));
  tba_ctrl_end tba_ctrl_end_i (
    .I_CLK(clk), .I_NRST(nrst), .BUS(tba_if_i), .I_WANT_BUS(want), .I_RECALL(recall),
    .O_OWNS_BUS(ctrl_owns), .I_CMD_VALID(c_v), .I_CMD_KIND(c_k), .I_CMD_TAG(c_tag),
    .I_CMD_INDEX(c_idx), .I_CMD_SECTOR(c_sec), .I_CMD_SET(c_set), .O_CMD_READY(ready),
    .O_RD_VALID(rd_v), .O_RD_TAG(rd_tag), .O_TAG_SET_SELECT(set_sel),
    .O_TAG_ADDR_WRITE_EN_N(twe_n), .O_STATE_WRITE_EN_N(swe_n), .O_STATE_READ_SEL_N(srd_n),
    .O_TAG_RAM_OE_N(ram_oe_n));
  tba_chk tba_chk_i (
    .I_CLK(clk), .I_NRST(nrst), .cpu_tbus_out(tba_if_i.cpu_tbus_out),
    .cpu_tbus_oe_n(tba_if_i.cpu_tbus_oe_n), .ctrl_tbus_out(tba_if_i.ctrl_tbus_out),
    .ctrl_tbus_oe_n(tba_if_i.ctrl_tbus_oe_n), .ctrl_bus_request_n(tba_if_i.ctrl_bus_request_n),
    .cpu_bus_release_n(tba_if_i.cpu_bus_release_n), .tbus(tba_if_i.tbus));
  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // tag field as it sits on the bus, rotated by two
  function automatic logic [19:0] rot(input logic [19:0] t);
    return {t[17:0], t[19:18]};
  endfunction
  // random core word; tag ram shows inverse data while not enabled
  always @(negedge clk) begin
    core_word <= 68'({$random(seed), $random(seed), $random(seed)});
    tag_in <= !ram_oe_n ? ram_tag : ~ram_tag;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      end_sim();
    end
  end
  task automatic miss(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [35:0] got, input logic [35:0] e, input string m);
    n_compared++;
    if (got !== e) miss(m);
  endtask
  task automatic cmp_rd(input logic [19:0] got);
    n_compared++;
    if (exp_rd.size() == 0 || got !== exp_rd.pop_front()) miss("read tag");
  endtask
  task automatic cmp_wr(input logic [35:0] got);
    n_compared++;
    if (exp_wr.size() == 0 || got !== exp_wr.pop_front()) miss("tag ram write");
  endtask
  // result watcher: oldest note against each result
  always @(negedge clk) begin
    if (nrst && rd_v === 1'h1) cmp_rd(rd_tag);
    if (nrst && twe_n === 1'h0) cmp_wr({set_sel, tag_pin, idx_pin, sec_pin, swe_n});
    if (nrst && ram_oe_n === 1'h0) cmp(36'({srd_n, tpin_oe_n}), 36'h3, "ram pins");
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic done(input string m);
    $display("test %s done", m);
  endtask
  task automatic wait_st(input logic [8:0] st);
    int k;
    k = 0;
    while (arb_st !== st && k < 2000) begin
      @(negedge clk);
      k++;
    end
    cmp(36'(arb_st), 36'(st), "arbiter state");
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    while (ready !== 1'h1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    cmp(36'(ready), 36'h1, "command ready");
  endtask
  // one controller command, noting the expected result
  task automatic cmd(input logic [1:0] k);
    wait_rdy();
    c_v = 1'h1;
    c_k = k;
    c_tag = 20'($random(seed));
    c_idx = 11'($random(seed));
    c_sec = 2'($random(seed));
    c_set = 2'($random(seed));
    ram_tag = 20'($random(seed));
    if (k == 2'h0) exp_wr.push_back({c_set, c_tag, c_idx, c_sec, 1'h1});
    if (k == 2'h1) exp_rd.push_back(ram_tag);
    @(negedge clk);
    c_v = 1'h0;
    if (k == 2'h0) cmp(36'(tb_bus[39:7]), 36'({rot(c_tag), c_idx, c_sec}), "write word");
    if (k == 2'h1) cmp(36'({tb_bus[67:64], tb_bus[19:9]}), 36'({4'h5, c_idx}), "read");
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'h0;
    {give_up, busy, q_empty, want, recall, c_v} = '0;
    {c_k, c_sec, c_set, c_tag, c_idx, ram_tag, core_word, tag_in} = '0;
    tick(8);
    nrst = 1'h1;
    tick(1);
    cmp(36'(arb_st), 36'(tba_pkg::ARB_RUN), "reset state");
    cmp(36'({tba_if_i.ctrl_bus_request_n, tba_if_i.cpu_bus_release_n}), 36'h3, "idle");
    done("reset");
    // request, grant, alternating writes and reads back to back
    want = 1'h1;
    wait_st(tba_pkg::ARB_REQUEST);
    wait_st(tba_pkg::ARB_CTRL_OWNS);
    for (int i = 0; i < 6; i++) cmd(2'(i % 2));
    tick(14);
    cmp(36'(exp_rd.size() + exp_wr.size()), 36'h0, "results missing");
    done("tag cycles");
    // queue drain to completion, then drain cut short by recall
    cmd(2'h2);
    wait_st(tba_pkg::ARB_QUEUE_DRAIN);
    cmp(36'({drain, cpu_owns}), 36'h3, "drain flags");
    tick(20);
    cmp(36'(arb_st), 36'(tba_pkg::ARB_QUEUE_DRAIN), "drain holds");
    q_empty = 1'h1;
    wait_st(tba_pkg::ARB_CTRL_OWNS);
    q_empty = 1'h0;
    cmd(2'h2);
    wait_st(tba_pkg::ARB_QUEUE_DRAIN);
    busy = 1'h1;
    recall = 1'h1;
    wait_st(tba_pkg::ARB_DRAIN_RECALL);
    tick(10);
    cmp(36'(arb_st), 36'(tba_pkg::ARB_DRAIN_RECALL), "recall waits");
    busy = 1'h0;
    wait_st(tba_pkg::ARB_CTRL_OWNS);
    recall = 1'h0;
    done("drain");
    // request dropped, bus back to cpu
    want = 1'h0;
    cmd(2'h3);
    wait_st(tba_pkg::ARB_RUN);
    cmp(36'({ctrl_owns, cpu_owns}), 36'h1, "owner after drop");
    done("drop");
    // release without any request
    tick(3);
    give_up = 1'h1;
    wait_st(tba_pkg::ARB_CTRL_OWNS);
    give_up = 1'h0;
    tick(1);
    if (ready === 1'h1) cmd(2'h3);
    wait_st(tba_pkg::ARB_RUN);
    done("unasked release");
    // busy cpu must still grant in time
    busy = 1'h1;
    want = 1'h1;
    t0 = cycles;
    wait_st(tba_pkg::ARB_CTRL_OWNS);
    cmp(36'(cycles - t0 > 1400 && cycles - t0 <= 1504), 36'h1, "grant time");
    busy = 1'h0;
    want = 1'h0;
    cmd(2'h3);
    wait_st(tba_pkg::ARB_RUN);
    done("slow grant");
    end_sim();
  end
endmodule
`default_nettype wire
